//--- ulf_aux.sv
`timescale 1ns/100ps
`default_nettype none

module ulf_aux (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  os_tick_in,
	input  wire ulf_pkg::ulf_cfg_t     cfg_in,
	input  wire ulf_pkg::ulf_char_wr_t char_wr_in,
	input  wire logic                  flag_clear_in,
	input  wire logic [7:0]            tx_data_in,
	input  wire logic                  tx_valid_in,
	output logic                       tx_ready_out,
	input  wire logic [7:0]            rx_level_in,
	output logic [7:0]                 rx_data_out,
	output logic                       rx_valid_out,
	input  wire logic                  rx_pin_in,
	output logic                       tx_pin_out,
	output logic                       rts_pin_out,
	output logic                       tx_paused_out,
	output logic                       flow_flag_out,
	output logic                       irq_out
);
	import ulf_pkg::*;

	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ulf_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ulf_rx_st_t;
	typedef enum logic [1:0] {FS_NORMAL, FS_WAIT, FS_SENT} ulf_flow_st_t;

	logic [7:0]   resume_char_first;
	logic [7:0]   resume_char_second;
	logic [7:0]   pause_char_first;
	logic [7:0]   pause_char_second;
	logic         rx_s1_q;
	logic         rx_s2_q;
	logic         rx_s3_q;
	logic         rx_line_q;
	logic         rx_nrz;
	ulf_tx_st_t   tx_st_q;
	logic [7:0]   tx_sh_q;
	logic [3:0]   tx_ph_q;
	logic [2:0]   tx_cnt_q;
	logic         tx_bit_q;
	ulf_rx_st_t   rx_st_q;
	logic [7:0]   rx_sh_q;
	logic [3:0]   rx_ph_q;
	logic [2:0]   rx_cnt_q;
	ulf_flow_st_t flow_st_q;
	logic [8:0]   dly_q;
	logic         req_xoff_q;
	logic         req_xon_q;
	logic         flow_second_q;
	logic         pend_v_q;
	logic         pend_xoff_q;
	logic [7:0]   pend_char_q;
	logic         spill_v_q;
	logic [7:0]   spill_q;
	logic         fifo_valid;
	logic [7:0]   fifo_data;
	logic         load_flow;
	logic         load_data;
	logic [7:0]   tx_char;
	logic         bit_end;
	logic         rx_bit_end;
	logic         rx_done;
	logic [7:0]   c;
	logic         is_p1;
	logic         is_p2;
	logic         is_r1;
	logic         is_r2;
	logic         hit_xoff;
	logic         hit_xon;
	logic         fwd_a_v;
	logic         fwd_b_v;
	logic         spec_hit;
	logic         flag_set;
	logic [2:0]   data_last;

	// ----------------------------------------
	// Flow character store
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			resume_char_first  <= CHAR_RST;
			resume_char_second <= CHAR_RST;
			pause_char_first   <= CHAR_RST;
			pause_char_second  <= CHAR_RST;
		end else if (char_wr_in.en) begin
			case (char_wr_in.sel)
				2'h0: resume_char_first <= char_wr_in.data;
				2'h1: resume_char_second <= char_wr_in.data;
				2'h2: pause_char_first <= char_wr_in.data;
				default: pause_char_second <= char_wr_in.data;
			endcase
		end
	end

	// ----------------------------------------
	// Receive pin synchroniser
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_s1_q   <= 1'b1;
			rx_s2_q   <= 1'b1;
			rx_s3_q   <= 1'b1;
			rx_line_q <= 1'b1;
		end else begin
			rx_s1_q <= rx_pin_in;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q) begin
				rx_line_q <= rx_s3_q;
			end
		end
	end

	ulf_irda u_irda (
		.ref_clk_in  (ref_clk_in),
		.rst_in      (rst_in),
		.os_tick_in  (os_tick_in),
		.irda_en_in  (cfg_in.irda_en),
		.rx_inv_in   (cfg_in.irda_rx_inv),
		.rx_line_in  (rx_line_q),
		.rx_nrz_out  (rx_nrz),
		.tx_nrz_in   (tx_bit_q),
		.tx_phase_in (tx_ph_q),
		.tx_pin_out  (tx_pin_out)
	);

	// Shallow buffer keeps the host decoupled while a flow char is inserted
	ulf_fifo #(.W(CHAR_W), .D(TX_FIFO_DEPTH)) u_tx_fifo (
		.ref_clk_in    (ref_clk_in),
		.rst_in        (rst_in),
		.in_data_in    (tx_data_in),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.out_data_out  (fifo_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (load_data)
	);

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	assign data_last = DATA_BASE_IDX + {1'b0, cfg_in.word_len};
	assign bit_end   = os_tick_in && tx_ph_q == BIT_LAST_PH;
	assign load_flow = tx_st_q == TX_IDLE && (req_xoff_q || req_xon_q);
	assign load_data = tx_st_q == TX_IDLE && !load_flow && fifo_valid && !tx_paused_out
		&& !(cfg_in.half_duplex_en && rts_pin_out);
	assign tx_char   = !load_flow ? fifo_data
		: req_xoff_q ? (flow_second_q ? pause_char_second : pause_char_first)
		: (flow_second_q ? resume_char_second : resume_char_first);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_st_q  <= TX_IDLE;
			tx_sh_q  <= 8'h00;
			tx_ph_q  <= 4'h0;
			tx_cnt_q <= 3'h0;
			tx_bit_q <= 1'b1;
		end else begin
			if (tx_st_q != TX_IDLE && os_tick_in) begin
				tx_ph_q <= tx_ph_q + 4'h1;
			end
			case (tx_st_q)
				TX_IDLE: begin
					tx_bit_q <= 1'b1;
					tx_ph_q  <= 4'h0;
					if (load_flow || load_data) begin
						tx_sh_q  <= tx_char;
						tx_bit_q <= 1'b0;
						tx_st_q  <= TX_START;
					end
				end
				TX_START: begin
					if (bit_end) begin
						tx_bit_q <= tx_sh_q[0];
						tx_sh_q  <= tx_sh_q >> 1;
						tx_cnt_q <= 3'h0;
						tx_st_q  <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (bit_end && tx_cnt_q == data_last) begin
						tx_bit_q <= 1'b1;
						tx_cnt_q <= 3'h0;
						tx_st_q  <= TX_STOP;
					end else if (bit_end) begin
						tx_bit_q <= tx_sh_q[0];
						tx_sh_q  <= tx_sh_q >> 1;
						tx_cnt_q <= tx_cnt_q + 3'h1;
					end
				end
				TX_STOP: begin
					if (bit_end && tx_cnt_q == {2'h0, cfg_in.two_stop}) begin
						tx_st_q <= TX_IDLE;
					end else if (bit_end) begin
						tx_cnt_q <= tx_cnt_q + 3'h1;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// Half-duplex turnaround; RTS falls a cycle before a data frame enters TX_START, but on the same edge as a flow char does
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rts_pin_out <= 1'b1;
		end else if (cfg_in.half_duplex_en) begin
			rts_pin_out <= !(fifo_valid || req_xoff_q || req_xon_q
				|| tx_st_q != TX_IDLE);
		end else begin
			rts_pin_out <= cfg_in.rts_level;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	assign rx_bit_end = os_tick_in && rx_ph_q == BIT_LAST_PH;
	assign rx_done    = rx_st_q == RX_STOP && rx_bit_end;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_st_q  <= RX_IDLE;
			rx_sh_q  <= 8'h00;
			rx_ph_q  <= 4'h0;
			rx_cnt_q <= 3'h0;
		end else begin
			if (os_tick_in) begin
				rx_ph_q <= rx_ph_q + 4'h1;
			end
			case (rx_st_q)
				RX_IDLE: begin
					rx_ph_q <= 4'h0;
					if (!rx_nrz) begin
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					if (os_tick_in && rx_ph_q == START_MID_PH) begin
						rx_ph_q  <= 4'h0;
						rx_cnt_q <= 3'h0;
						rx_sh_q  <= 8'h00;
						rx_st_q  <= rx_nrz ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_bit_end) begin
						rx_sh_q[rx_cnt_q] <= rx_nrz;
						rx_cnt_q          <= rx_cnt_q + 3'h1;
						if (rx_cnt_q == data_last) begin
							rx_st_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_bit_end) begin
						rx_st_q <= RX_IDLE;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Received flow character match
	// ----------------------------------------
	assign c     = ulf_mask(rx_sh_q, cfg_in.word_len);
	assign is_p1 = c == ulf_mask(pause_char_first, cfg_in.word_len);
	assign is_p2 = c == ulf_mask(pause_char_second, cfg_in.word_len);
	assign is_r1 = c == ulf_mask(resume_char_first, cfg_in.word_len);
	assign is_r2 = c == ulf_mask(resume_char_second, cfg_in.word_len);

	always_comb begin
		hit_xoff = 1'b0;
		hit_xon  = 1'b0;
		fwd_a_v  = 1'b0;
		fwd_b_v  = 1'b0;
		if (rx_done) begin
			case (cfg_in.rx_fc_mode)
				FC_SINGLE: begin
					hit_xoff = is_p1;
					hit_xon  = !is_p1 && is_r1;
					fwd_b_v  = !(is_p1 || is_r1);
				end
				FC_DOUBLE: begin
					if (pend_v_q && (pend_xoff_q ? is_p2 : is_r2)) begin
						hit_xoff = pend_xoff_q;
						hit_xon  = !pend_xoff_q;
					end else begin
						fwd_a_v = pend_v_q;
						fwd_b_v = !(is_p1 || is_r1);
					end
				end
				default: fwd_b_v = 1'b1;
			endcase
		end
		spec_hit = cfg_in.special_en && is_p2 && fwd_b_v;
		flag_set = (hit_xoff && cfg_in.xoff_irq_en) || spec_hit;
	end

	// First char of a possible pair is held back until the next one decides
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_v_q    <= 1'b0;
			pend_xoff_q <= 1'b0;
			pend_char_q <= 8'h00;
		end else if (cfg_in.rx_fc_mode != FC_DOUBLE) begin
			pend_v_q <= 1'b0;
		end else if (rx_done) begin
			pend_v_q    <= !(hit_xoff || hit_xon) && (is_p1 || is_r1);
			pend_xoff_q <= is_p1;
			pend_char_q <= c;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_valid_out <= 1'b0;
			rx_data_out  <= 8'h00;
			spill_v_q    <= 1'b0;
			spill_q      <= 8'h00;
		end else begin
			rx_valid_out <= fwd_a_v || fwd_b_v || spill_v_q;
			if (fwd_a_v) begin
				rx_data_out <= pend_char_q;
				spill_v_q   <= fwd_b_v;
				spill_q     <= c;
			end else if (fwd_b_v) begin
				rx_data_out <= c;
			end else if (spill_v_q) begin
				rx_data_out <= spill_q;
				spill_v_q   <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Pause state and status
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_paused_out <= 1'b0;
			flow_flag_out <= 1'b0;
			irq_out       <= 1'b0;
		end else begin
			if (cfg_in.rx_fc_mode == FC_OFF || hit_xon) begin
				tx_paused_out <= 1'b0;
			end else if (hit_xoff) begin
				tx_paused_out <= 1'b1;
			end
			// Set beats a same-cycle clear so no event is lost
			flow_flag_out <= flag_set || (flow_flag_out && !hit_xon && !flag_clear_in);
			irq_out       <= flag_set || (flow_flag_out && !hit_xon && !flag_clear_in);
		end
	end

	// ----------------------------------------
	// Automatic Xoff / Xon generation
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flow_st_q     <= FS_NORMAL;
			dly_q         <= 9'h000;
			req_xoff_q    <= 1'b0;
			req_xon_q     <= 1'b0;
			flow_second_q <= 1'b0;
		end else begin
			if (load_flow && cfg_in.tx_fc_mode == FC_DOUBLE && !flow_second_q) begin
				flow_second_q <= 1'b1;
			end else if (load_flow) begin
				flow_second_q <= 1'b0;
				req_xoff_q    <= 1'b0;
				req_xon_q     <= 1'b0;
			end
			case (flow_st_q)
				FS_NORMAL: begin
					dly_q <= 9'h000;
					if (cfg_in.tx_fc_mode != FC_OFF && rx_level_in >= cfg_in.trig_level) begin
						flow_st_q <= FS_WAIT;
					end
				end
				FS_WAIT: begin
					if (cfg_in.tx_fc_mode == FC_OFF || rx_level_in < cfg_in.trig_level) begin
						flow_st_q <= FS_NORMAL;
					end else if (os_tick_in && dly_q == ulf_xoff_ticks(cfg_in.word_len,
							cfg_in.two_stop)) begin
						req_xoff_q    <= 1'b1;
						req_xon_q     <= 1'b0;
						flow_second_q <= 1'b0;
						flow_st_q     <= FS_SENT;
					end else if (os_tick_in) begin
						dly_q <= dly_q + 9'h001;
					end
				end
				FS_SENT: begin
					if (cfg_in.tx_fc_mode == FC_OFF) begin
						flow_st_q <= FS_NORMAL;
					end else if (rx_level_in <= ulf_xon_level(cfg_in.trig_table,
							cfg_in.trig_level, cfg_in.hyst)) begin
						req_xon_q     <= 1'b1;
						req_xoff_q    <= 1'b0;
						flow_second_q <= 1'b0;
						flow_st_q     <= FS_NORMAL;
					end
				end
				default: flow_st_q <= FS_NORMAL;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_xoff_seen;
		hit_xoff && cfg_in.rx_fc_mode != FC_OFF;
	endsequence

	a_xoff_pause: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_xoff_seen ##1 !hit_xon |=> tx_paused_out)
		else $error("xoff did not pause transmitter");
	a_pause_no_start: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		tx_paused_out && tx_st_q == TX_IDLE && !load_flow |=> tx_st_q == TX_IDLE)
		else $error("data started while paused");
	a_xoff_irq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		s_xoff_seen and cfg_in.xoff_irq_en |=> flow_flag_out && irq_out)
		else $error("xoff flag or interrupt missing");
	a_xon_resume: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		hit_xon && !spec_hit |=> !tx_paused_out && !flow_flag_out)
		else $error("xon did not resume");
	a_flow_dropped: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(hit_xoff || hit_xon) && !spill_v_q |=> !rx_valid_out)
		else $error("flow char forwarded");
	a_special_kept: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		spec_hit |=> rx_valid_out && rx_data_out == $past(c) && flow_flag_out)
		else $error("special char not stored");
	a_rts_before_tx: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		cfg_in.half_duplex_en && $stable(cfg_in.half_duplex_en) && tx_st_q != TX_IDLE
		|-> !rts_pin_out)
		else $error("send began with rts high");
	a_flow_boundary: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		load_flow |-> tx_bit_q && tx_ph_q == 4'h0)
		else $error("flow char inside a frame");

endmodule // ulf_aux

`default_nettype wire

//--- ulf_aux_test.sv
`timescale 1ns/100ps
`default_nettype none

module ulf_aux_test;
	import ulf_pkg::*;
	logic         ref_clk_in, rst_in, fclr, txv, txr, rxv, rxp, txp, rts, pau, ff, irq;
	logic [7:0]   txd, lvl, rxd, b;
	logic [7:0]   r[4];
	logic [7:0]   rq[$];
	ulf_cfg_t     cfg;
	ulf_char_wr_t cw;
	int           err_total = 0, comparisons = 0, seed = 32'h4fbd, n;

	ulf_aux DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .os_tick_in(1'b1),
		.cfg_in(cfg), .char_wr_in(cw), .flag_clear_in(fclr), .tx_data_in(txd),
		.tx_valid_in(txv), .tx_ready_out(txr), .rx_level_in(lvl), .rx_data_out(rxd),
		.rx_valid_out(rxv), .rx_pin_in(rxp), .tx_pin_out(txp), .rts_pin_out(rts),
		.tx_paused_out(pau), .flow_flag_out(ff), .irq_out(irq));
	ulf_far far (.clk_in(ref_clk_in), .tx_in(txp), .ir_in(cfg.irda_en),
		.inv_in(cfg.irda_rx_inv), .rx_out(rxp));

	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) if (rxv === 1'b1) rq.push_back(rxd);
	// Far longer than the whole sequence needs
	initial begin
		#(50 * 40000);
		err_total++;
		conclude();
	end

	function automatic logic [7:0] irp(input logic [7:0] v);
		return 8'(3 * (9 - $countones(v)));
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk_in);
	endtask
	task automatic push(input logic [7:0] v);
		txd = v;
		txv = 1'b1;
		do @(posedge ref_clk_in); while (txr !== 1'b1);
		@(negedge ref_clk_in);
	endtask
	task automatic wc(input logic [1:0] s, input logic [7:0] d);
		cw = '{1'b1, s, d};
		cyc(1);
		cw.en = 1'b0;
	endtask
	task automatic gr(input logic [7:0] e);
		for (int i = 0; i < 3000 && rq.size() == 0; i++) cyc(1);
		chk(rq.size() ? rq.pop_front() : 8'hxx, e);
	endtask
	task automatic gf(input logic [7:0] e);
		for (int i = 0; i < 3000 && far.q.size() == 0; i++) cyc(1);
		chk(far.q.size() ? far.q.pop_front() : 8'hxx, e);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		cfg = '0;
		cfg.word_len = 2'h3;
		cfg.rts_level = 1'b1;
		cw = '0;
		{fclr, txv, txd, lvl} = '0;
		rst_in = 1'b1;
		cyc(4);
		rst_in = 1'b0;
		cyc(2);
		chk(8'(rts), 8'h01);
		cfg.rx_fc_mode = FC_SINGLE;
		cfg.xoff_irq_en = 1'b1;
		far.send(8'h13);
		gr(8'h13);
		wc(2'h2, 8'h13);
		wc(2'h0, 8'h11);
		wc(2'h3, 8'h5A);
		for (int i = 0; i < 4; i++) begin
			r[i] = 8'($random(seed));
			push(r[i]);
		end
		txv = 1'b0;
		for (int i = 0; i < 4; i++) gf(r[i]);
		$display("test 1 done");
		far.send(8'h13);
		cyc(8);
		chk(8'(pau), 8'h01);
		chk(8'(irq), 8'h01);
		chk(8'(rq.size()), 8'h00);
		push(8'hA5);
		txv = 1'b0;
		cyc(400);
		chk(8'(far.q.size()), 8'h00);
		far.send(8'h11);
		cyc(8);
		chk(8'(ff), 8'h00);
		gf(8'hA5);
		cfg.rx_fc_mode = FC_OFF;
		cfg.special_en = 1'b1;
		far.send(8'h5A);
		gr(8'h5A);
		chk(8'(ff), 8'h01);
		cfg.special_en = 1'b0;
		$display("test 2 done");
		cfg.tx_fc_mode = FC_DOUBLE;
		cfg.trig_table = 2'h1;
		cfg.trig_level = 8'h10;
		lvl = 8'h10;
		cyc(300);
		chk(8'(far.q.size()), 8'h00);
		gf(8'h13);
		gf(8'h5A);
		lvl = 8'h09;
		cyc(400);
		chk(8'(far.q.size()), 8'h00);
		lvl = 8'h08;
		gf(8'h11);
		gf(8'h00);
		cfg.tx_fc_mode = FC_OFF;
		cfg.half_duplex_en = 1'b1;
		cyc(40);
		chk(8'(rts), 8'h01);
		push(8'h3C);
		txv = 1'b0;
		@(negedge txp);
		chk(8'(rts), 8'h00);
		gf(8'h3C);
		chk(8'(rts), 8'h00);
		cyc(40);
		chk(8'(rts), 8'h01);
		$display("test 3 done");
		cfg.half_duplex_en = 1'b0;
		cfg.irda_en = 1'b1;
		cyc(4);
		chk(8'(txp), 8'h00);
		b = 8'($random(seed));
		push(b);
		txv = 1'b0;
		n = 0;
		repeat (220) @(posedge ref_clk_in) n += int'(txp);
		chk(8'(n), irp(b));
		// Polarity flips can fake a frame, so flush after
		for (int v = 0; v < 2; v++) begin
			cfg.irda_rx_inv = v[0];
			cyc(400);
			rq.delete();
			b = 8'($random(seed));
			far.send(b);
			gr(b);
		end
		$display("test 4 done");
		cfg.irda_en = 1'b0;
		cfg.irda_rx_inv = 1'b0;
		cfg.rx_fc_mode = FC_DOUBLE;
		fclr = 1'b1;
		cyc(1);
		fclr = 1'b0;
		chk(8'(ff), 8'h00);
		chk(8'(irq), 8'h00);
		wc(2'h1, 8'h22);
		far.send(8'h13);
		far.send(8'h5A);
		cyc(8);
		chk(8'(pau), 8'h01);
		chk(8'(ff), 8'h01);
		chk(8'(rq.size()), 8'h00);
		far.send(8'h13);
		far.send(8'h77);
		gr(8'h13);
		gr(8'h77);
		far.send(8'h11);
		far.send(8'h22);
		cyc(8);
		chk(8'(pau), 8'h00);
		chk(8'(ff), 8'h00);
		// Upper bits of the stored char differ, so only a masked compare hits
		cfg.rx_fc_mode = FC_SINGLE;
		cfg.word_len = 2'h1;
		wc(2'h2, 8'hD3);
		far.send(8'hD3);
		cyc(8);
		chk(8'(pau), 8'h01);
		far.send(8'hD1);
		cyc(8);
		chk(8'(pau), 8'h00);
		$display("test 5 done");
		conclude();
	end
endmodule // ulf_aux_test

`default_nettype wire

//--- ulf_far.sv
`timescale 1ns/100ps
`default_nettype none

module ulf_far (
	input  wire logic clk_in,
	input  wire logic tx_in,
	input  wire logic ir_in,
	input  wire logic inv_in,
	output logic      rx_out
);
	logic       busy = 1'b0;
	logic       drv  = 1'b1;
	logic [7:0] q[$];

	// Mark idle; infrared rest level follows polarity
	assign rx_out = busy ? drv : (ir_in ? inv_in : 1'b1);

	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		busy = 1'b1;
		for (int i = 0; i < 10; i++) begin
			for (int t = 0; t < 16; t++) begin
				drv = ir_in ? (inv_in ^ (!f[i] && t < 3)) : f[i];
				@(negedge clk_in);
			end
		end
		busy = 1'b0;
	endtask

	// Mid-bit capture, plain line only
	always begin : cap
		logic [7:0] b;
		@(negedge tx_in);
		if (!ir_in) begin
			repeat (8) @(posedge clk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (16) @(posedge clk_in);
				b[i] = tx_in;
			end
			q.push_back(b);
			repeat (16) @(posedge clk_in);
		end
	end
endmodule // ulf_far

`default_nettype wire

//--- ulf_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module ulf_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         ref_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] in_data_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	output logic [W-1:0]      out_data_out,
	output logic              out_valid_out,
	input  wire logic         out_ready_in
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;
	logic [AW:0]   cnt_d;

	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_valid_out = cnt_q != '0;
	assign out_data_out  = mem_q[rd_q];
	assign cnt_d         = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_q         <= '0;
			rd_q         <= '0;
			cnt_q        <= '0;
			in_ready_out <= 1'b0;
		end else begin
			wr_q         <= push ? AW'((wr_q + 1'b1) % D) : wr_q;
			rd_q         <= pop ? AW'((rd_q + 1'b1) % D) : rd_q;
			cnt_q        <= cnt_d;
			in_ready_out <= cnt_d < (AW+1)'(D);
		end
	end

	a_fifo_no_overrun: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		cnt_q <= (AW+1)'(D))
		else $error("fifo count above depth");

endmodule // ulf_fifo

`default_nettype wire

//--- ulf_irda.sv
`timescale 1ns/100ps
`default_nettype none

module ulf_irda (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       os_tick_in,
	input  wire logic       irda_en_in,
	input  wire logic       rx_inv_in,
	input  wire logic       rx_line_in,
	output logic            rx_nrz_out,
	input  wire logic       tx_nrz_in,
	input  wire logic [3:0] tx_phase_in,
	output logic            tx_pin_out
);
	import ulf_pkg::*;

	logic       pulse;
	logic       pulse_prev_q;
	logic [4:0] hold_q;

	// ----------------------------------------
	// Encoder
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_pin_out <= 1'b1;
		end else if (irda_en_in) begin
			tx_pin_out <= !tx_nrz_in && (tx_phase_in < IR_PULSE_TICKS);
		end else begin
			tx_pin_out <= tx_nrz_in;
		end
	end

	// ----------------------------------------
	// Decoder
	// ----------------------------------------
	// Pulse is stretched over one bit so the receiver samples it mid-bit
	assign pulse = rx_line_in ^ rx_inv_in;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pulse_prev_q <= 1'b1;
			hold_q       <= 5'h00;
			rx_nrz_out   <= 1'b1;
		end else begin
			pulse_prev_q <= pulse;
			if (pulse && !pulse_prev_q) begin
				hold_q <= IR_HOLD_TICKS;
			end else if (os_tick_in && hold_q != 5'h00) begin
				hold_q <= hold_q - 5'h01;
			end
			rx_nrz_out <= irda_en_in ? (hold_q == 5'h00 && !(pulse && !pulse_prev_q)) : rx_line_in;
		end
	end

	a_ir_zero_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		irda_en_in && !tx_nrz_in && tx_phase_in == 4'h0 |=> tx_pin_out)
		else $error("no infrared pulse for zero bit");
	a_ir_one_dark: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		irda_en_in && tx_nrz_in |=> !tx_pin_out)
		else $error("infrared output not idle low");
	a_ir_pulse_decode: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		irda_en_in && $stable(irda_en_in) && pulse && !pulse_prev_q |=> !rx_nrz_out [*2])
		else $error("sensed pulse not decoded as low");

endmodule // ulf_irda

`default_nettype wire

//--- ulf_pkg.sv
`default_nettype none

package ulf_pkg;

	// ----------------------------------------
	// Timing and reset values
	// ----------------------------------------
	localparam int         CHAR_W          = 8;
	localparam int         TX_FIFO_DEPTH   = 4;
	localparam logic [3:0] BIT_LAST_PH     = 4'hF;
	localparam logic [3:0] START_MID_PH    = 4'h7;
	localparam logic [3:0] IR_PULSE_TICKS  = 4'h3;
	localparam logic [4:0] IR_HOLD_TICKS   = 5'h10;
	localparam logic [2:0] DATA_BASE_IDX   = 3'h4;
	localparam logic [3:0] FRAME_BASE_BITS = 4'h7;
	localparam logic [8:0] BIT_TICKS       = 9'h010;
	localparam logic [8:0] XOFF_DELAY_CHRS = 9'h002;
	localparam logic [7:0] CHAR_RST        = 8'h00;

	// ----------------------------------------
	// Trigger tables A, B, C
	// ----------------------------------------
	localparam logic [1:0] TBL_SEL_D = 2'h3;
	localparam logic [7:0] TRIG_TABLES [3][4] = '{
		'{8'h04, 8'h08, 8'h0C, 8'h10},
		'{8'h08, 8'h10, 8'h18, 8'h1C},
		'{8'h10, 8'h20, 8'h30, 8'h38}
	};

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {FC_OFF, FC_SINGLE, FC_DOUBLE} ulf_fc_mode_t;

	typedef struct packed {
		logic [1:0]   word_len;
		logic         two_stop;
		ulf_fc_mode_t rx_fc_mode;
		ulf_fc_mode_t tx_fc_mode;
		logic         special_en;
		logic         xoff_irq_en;
		logic         half_duplex_en;
		logic         irda_en;
		logic         irda_rx_inv;
		logic         rts_level;
		logic [1:0]   trig_table;
		logic [7:0]   trig_level;
		logic [7:0]   hyst;
	} ulf_cfg_t;

	typedef struct packed {
		logic       en;
		logic [1:0] sel;
		logic [7:0] data;
	} ulf_char_wr_t;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] ulf_mask(input logic [7:0] c, input logic [1:0] wl);
		return c & (8'hFF >> (2'h3 - wl));
	endfunction

	function automatic logic [8:0] ulf_xoff_ticks(input logic [1:0] wl, input logic two_stop);
		logic [8:0] bits;
		bits = {5'h00, FRAME_BASE_BITS} + {7'h00, wl} + {8'h00, two_stop};
		return 9'((bits * BIT_TICKS * XOFF_DELAY_CHRS) - 9'h001);
	endfunction

	function automatic logic [7:0] ulf_xon_level(input logic [1:0] tbl, input logic [7:0] trig,
			input logic [7:0] hyst);
		logic [7:0] lvl;
		lvl = 8'h00;
		if (tbl == TBL_SEL_D) begin
			lvl = (trig > hyst) ? 8'(trig - hyst) : 8'h00;
		end else begin
			for (int i = 1; i < 4; i++) begin
				if (TRIG_TABLES[tbl][i] == trig) begin
					lvl = TRIG_TABLES[tbl][i - 1];
				end
			end
		end
		return lvl;
	endfunction

endpackage

`default_nettype wire
